// [core/pllirq_top.sv]
// clock generator lock-change interrupt, stop/wait and break handling
// assumes axi4-lite master, crystal/vco levels and cpu mode lines from pins
// Function
// - in self bandwidth mode every settled change raises the event
// - cpu request only when pll_irq_enable set (clockgen_irq); irq_out follows masked status regardless of it
// - lock_change_flag sets whether or not interrupt enabled
// - bandwidth mode off: no request, flag reads zero
// - base clock may select vco even while unsettled
// - wait instruction changes nothing in the clock generator
// - lock-change interrupt can wake processor from wait
// - stop without osc keep: osc and loop off, clock outputs and clockgen_irq low
// - stop with osc keep: loop off, crystal clock continues
// - break with clear enable: status clears persist afterwards
// - break without clear enable: loop control access keeps flag
// - otherwise any loop control read clears lock_change_flag
// - vco_settled read-only, reads zero unless self bandwidth mode
// - base clock held static up to three cycles on switch
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
module pllirq_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_level,
  input  wire logic        vco_level,
  input  wire logic        vco_locked,
  input  wire logic        keep_osc_in_stop,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        break_state,
  input  wire logic        break_clear_enable,
  output logic             crystal_clock,
  output logic             base_clock_out,
  output logic             clockgen_irq,
  output logic             irq_out,
  output logic             osc_enable,
  output logic             pll_enable,
  output logic             wake_request
);
  // ---------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  logic [7:0] pin_s;
  pllirq_sync #(.W(8)) u_sync (
    .clock (clock),
    .rst_n (rst_sync_n),
    .d     ({osc_level, vco_level, vco_locked, keep_osc_in_stop, stop_mode,
             wait_mode, break_state, break_clear_enable}),
    .q     (pin_s)
  );
  logic osc_s, vco_s, lock_s, keep_s, stop_s, wait_s, brk_s, break_clear_enable_s;
  assign {osc_s, vco_s, lock_s, keep_s, stop_s, wait_s, brk_s, break_clear_enable_s} = pin_s;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic       irq_en_reg, pll_on_reg, bcs_reg, auto_reg, flag_reg;
  logic [pllirq_pkg::EV_W-1:0] ev_status_reg, ev_mask_reg;
  logic       settled, settled_prev_reg, lock_event;
  logic       protect, stop_all;

  // settled only meaningful in self bandwidth mode
  assign settled  = auto_reg & lock_s;
  assign protect  = brk_s & ~break_clear_enable_s;
  assign stop_all = stop_s & ~keep_s;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      settled_prev_reg <= 1'b0;
    end else begin
      settled_prev_reg <= settled;
    end
  end
  assign lock_event = auto_reg & (settled != settled_prev_reg);

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic        aw_have_reg, w_have_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire, rd_fire;
  logic [7:0]  rd_addr;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == pllirq_pkg::OFF_LOOP_CTRL) || (a == pllirq_pkg::OFF_BW_CTRL) ||
             (a == pllirq_pkg::OFF_IRQ_STATUS) || (a == pllirq_pkg::OFF_IRQ_MASK) ||
             (a == pllirq_pkg::OFF_MODE_STATUS);
  endfunction : mapped

  assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr[7:0];

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pllirq_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_reg) ? pllirq_pkg::RESP_OKAY
                                            : pllirq_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_loop, wr_bw, wr_stat, wr_mask;
  assign wr_loop = wr_fire & w_strb_reg[0] & (aw_addr_reg == pllirq_pkg::OFF_LOOP_CTRL);
  assign wr_bw   = wr_fire & w_strb_reg[0] & (aw_addr_reg == pllirq_pkg::OFF_BW_CTRL);
  assign wr_stat = wr_fire & w_strb_reg[0] & (aw_addr_reg == pllirq_pkg::OFF_IRQ_STATUS);
  assign wr_mask = wr_fire & w_strb_reg[0] & (aw_addr_reg == pllirq_pkg::OFF_IRQ_MASK);

  // read channel: one cycle arready, data the next
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pllirq_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(rd_addr) ? pllirq_pkg::RESP_OKAY : pllirq_pkg::RESP_SLVERR;
        case (rd_addr)
          pllirq_pkg::OFF_LOOP_CTRL:
            s_axi_rdata <= {24'h000000, irq_en_reg, flag_reg & auto_reg, pll_on_reg,
                            bcs_reg, 4'h0};
          pllirq_pkg::OFF_BW_CTRL:
            s_axi_rdata <= {24'h000000, auto_reg, settled, 6'h00};
          pllirq_pkg::OFF_IRQ_STATUS:
            s_axi_rdata <= {30'h00000000, ev_status_reg};
          pllirq_pkg::OFF_IRQ_MASK:
            s_axi_rdata <= {30'h00000000, ev_mask_reg};
          pllirq_pkg::OFF_MODE_STATUS:
            s_axi_rdata <= {27'h0000000, brk_s, stop_s, wait_s, keep_s, lock_s};
          default:
            s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control bits (wait mode has no effect on them)
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_en_reg <= pllirq_pkg::RST_LOOP_CTRL[pllirq_pkg::BIT_IRQ_EN];
      pll_on_reg <= pllirq_pkg::RST_LOOP_CTRL[pllirq_pkg::BIT_PLL_ON];
      bcs_reg    <= pllirq_pkg::RST_LOOP_CTRL[pllirq_pkg::BIT_BCS];
      auto_reg   <= pllirq_pkg::RST_BW_CTRL[pllirq_pkg::BIT_AUTO];
    end else begin
      if (wr_loop) begin
        irq_en_reg <= w_data_reg[pllirq_pkg::BIT_IRQ_EN];
        // bcs not gated by lock state
        bcs_reg    <= w_data_reg[pllirq_pkg::BIT_BCS];
        pll_on_reg <= w_data_reg[pllirq_pkg::BIT_PLL_ON];
      end
      if (wr_bw) begin
        auto_reg <= w_data_reg[pllirq_pkg::BIT_AUTO];
      end
    end
  end

  // ---------------------------------------------------------------
  // lock change flag: set wins over any clear
  // ---------------------------------------------------------------
  logic flag_clear;
  assign flag_clear = ~protect & ((rd_fire & (rd_addr == pllirq_pkg::OFF_LOOP_CTRL))
                                  | wr_loop);
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flag_reg <= 1'b0;
    end else if (lock_event) begin
      flag_reg <= 1'b1;
    end else if (~auto_reg) begin
      flag_reg <= 1'b0;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status / mask
  // ---------------------------------------------------------------
  logic [pllirq_pkg::EV_W-1:0] ev_set;
  assign ev_set = {pllirq_pkg::EV_W{1'b0}} | (2'(lock_event) << pllirq_pkg::BIT_EV_LOCK)
                  | (2'(wr_loop & ~protect & flag_reg) << pllirq_pkg::BIT_EV_SW);
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ev_status_reg <= '0;
    end else begin
      // break protection also guards w1c
      ev_status_reg <= (ev_status_reg & ~((wr_stat & ~protect) ?
                        w_data_reg[pllirq_pkg::EV_W-1:0] : 2'b00)) | ev_set;
    end
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ev_mask_reg <= '0;
    end else if (wr_mask) begin
      ev_mask_reg <= w_data_reg[pllirq_pkg::EV_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // clocks, stop mode and outputs
  // ---------------------------------------------------------------
  logic base_raw;
  pllirq_clksw u_clksw (
    .clock    (clock),
    .rst_n    (rst_sync_n),
    .sel      (bcs_reg),
    .xtal_lvl (osc_s),
    .vco_lvl  (vco_s & pll_on_reg & ~stop_s),
    .stop_all (stop_all),
    .base_out (base_raw),
    .busy     ()
  );

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      crystal_clock  <= 1'b0;
      base_clock_out <= 1'b0;
      clockgen_irq   <= 1'b0;
      irq_out        <= 1'b0;
      osc_enable     <= 1'b0;
      pll_enable     <= 1'b0;
      wake_request   <= 1'b0;
    end else begin
      crystal_clock  <= osc_s & ~stop_all;
      base_clock_out <= base_raw & ~stop_all;
      clockgen_irq   <= flag_reg & auto_reg & irq_en_reg & ~stop_all;
      irq_out        <= |(ev_status_reg & ev_mask_reg);
      osc_enable     <= ~stop_all;
      pll_enable     <= pll_on_reg & ~stop_s;
      wake_request   <= wait_s & flag_reg & auto_reg & irq_en_reg;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  a_event_sets_flag: assert property (lock_event |=> flag_reg)
    else $error("lock change did not set flag");
  a_flag_no_enable: assert property (lock_event && !irq_en_reg |=> flag_reg)
    else $error("flag not set with irq disabled");
  a_irq_gated: assert property (clockgen_irq |-> $past(irq_en_reg))
    else $error("irq without enable");
  a_auto_off_quiet: assert property (!auto_reg |=> !flag_reg && !clockgen_irq ##0 1)
    else $error("irq or flag with auto clear");
  a_irq_follows: assert property (flag_reg && auto_reg && irq_en_reg && !stop_all
                                  |=> clockgen_irq)
    else $error("irq not raised");
  a_break_keeps: assert property (protect && flag_reg && auto_reg |=> flag_reg)
    else $error("flag lost in protected break");
  a_break_w1c: assert property (wr_stat && protect
                                |=> (ev_status_reg & $past(ev_status_reg)) == $past(ev_status_reg))
    else $error("status cleared in protected break");
  a_write_clears: assert property (wr_loop && !protect && !lock_event |=> !flag_reg)
    else $error("loop control write did not clear flag");
  a_read_clears: assert property (rd_fire && rd_addr == pllirq_pkg::OFF_LOOP_CTRL
                                  && !protect && !lock_event |=> !flag_reg)
    else $error("loop control read did not clear flag");
  a_stop_low: assert property (stop_all [*2] |=> !crystal_clock && !base_clock_out
                               && !clockgen_irq)
    else $error("outputs not low in stop");
  a_stop_keep_osc: assert property (stop_s && keep_s |=> osc_enable && !pll_enable)
    else $error("keep osc stop wrong");
  a_bcs_free: assert property (wr_loop && w_data_reg[pllirq_pkg::BIT_BCS] |=> bcs_reg)
    else $error("bcs write blocked");
  a_wait_wake: assert property (wait_s && flag_reg && auto_reg && irq_en_reg
                                |=> wake_request)
    else $error("no wake from wait");

  c_lock_irq: cover property (lock_event ##1 clockgen_irq);
  c_break_read: cover property (protect && rd_fire);
  c_stop_entry: cover property (stop_all ##1 !crystal_clock);
  c_switch: cover property ($rose(bcs_reg) ##[1:8] base_clock_out);
endmodule : pllirq_top

// [shared/pllirq_pkg.sv]
// clock generator lock interrupt and low-power block: shared constants
// assumes 32-bit axi4-lite register access, one aligned word per register
package pllirq_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_LOOP_CTRL   = 8'h00;
  localparam logic [7:0] OFF_BW_CTRL     = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h0C;
  localparam logic [7:0] OFF_MODE_STATUS = 8'h10;
  // loop control fields
  localparam int BIT_IRQ_EN   = 7;
  localparam int BIT_LOCK_FLG = 6;
  localparam int BIT_PLL_ON   = 5;
  localparam int BIT_BCS      = 4;
  // bandwidth control fields
  localparam int BIT_AUTO     = 7;
  localparam int BIT_SETTLED  = 6;
  // interrupt status fields
  localparam int BIT_EV_LOCK  = 0;
  localparam int BIT_EV_SW    = 1;
  localparam int EV_W         = 2;
  // reset values
  localparam logic [7:0] RST_LOOP_CTRL = 8'h20;
  localparam logic [7:0] RST_BW_CTRL   = 8'h00;
  // clock switch hold, in clock cycles
  localparam int SWITCH_CYCLES = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pllirq_pkg

// [core/pllirq_sync.sv]
// two-flop synchroniser for level inputs
// assumes destination clock is clock
`timescale 1ns/100ps
module pllirq_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : pllirq_sync

// [core/pllirq_clksw.sv]
// base clock source switch: hold output static while source changes
// assumes both source clocks are sampled as synchronised levels
`timescale 1ns/100ps
module pllirq_clksw #(
  parameter int HOLD = pllirq_pkg::SWITCH_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic sel,
  input  wire logic xtal_lvl,
  input  wire logic vco_lvl,
  input  wire logic stop_all,
  output logic      base_out,
  output logic      busy
);
  logic       cur_reg;
  logic [2:0] cnt_reg;
  logic       src;
  assign src = cur_reg ? vco_lvl : xtal_lvl;
  // hold count, then adopt new source
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= 1'b0;
      cnt_reg <= 3'h0;
    end else if (sel != cur_reg) begin
      if (cnt_reg == 3'(HOLD - 1)) begin
        cur_reg <= sel;
        cnt_reg <= 3'h0;
      end else begin
        cnt_reg <= cnt_reg + 3'h1;
      end
    end else begin
      cnt_reg <= 3'h0;
    end
  end
  // divide by two of selected source, static during switch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      base_out <= 1'b0;
    end else if (stop_all) begin
      base_out <= 1'b0;
    end else if (sel == cur_reg && src) begin
      base_out <= ~base_out;
    end
  end
  assign busy = (sel != cur_reg);
endmodule : pllirq_clksw

// [sim/pllirq_sim_model.sv]
// system integration side: cpu wait entry and exit towards the block
// assumes one shared clock, bench pulses go_wait for one cycle
`timescale 1ns/100ps
module pllirq_sim_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic go_wait,
  input  wire logic wake_request,
  output logic      wait_mode
);
  // ----------------------------------------
  // wait entry and wake-up exit
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_mode <= 1'b0;
    end else if (wake_request) begin
      wait_mode <= 1'b0;
    end else if (go_wait) begin
      wait_mode <= 1'b1;
    end
  end
endmodule : pllirq_sim_model

// [sim/test_pll_lock_interrupt_lowpower.sv]
// self-checking bench: axi4-lite master, register model, mode stimulus
// assumes pllirq_top and pllirq_sim_model compiled first
`timescale 1ns/100ps
module test_pll_lock_interrupt_lowpower;
  logic        clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, go_wait, t;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rng;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        osc_level, vco_level, vco_locked, keep_osc_in_stop, stop_mode, wait_mode;
  logic        break_state, break_clear_enable, crystal_clock, base_clock_out;
  logic        clockgen_irq, irq_out, osc_enable, pll_enable, wake_request;
  int          errors, n_checks, tog, m_ctrl, m_auto, m_flag, m_lock, m_stat, m_mask;
  bit          m_brk, m_bce;

  pllirq_top dut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_level, .vco_level,
    .vco_locked, .keep_osc_in_stop, .stop_mode, .wait_mode, .break_state,
    .break_clear_enable, .crystal_clock, .base_clock_out, .clockgen_irq, .irq_out,
    .osc_enable, .pll_enable, .wake_request);
  pllirq_sim_model sim_side (.clock, .rst_n, .go_wait, .wake_request, .wait_mode);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic logic [1:0] rsp(input logic [7:0] a);
    if (a inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}) return pllirq_pkg::RESP_OKAY;
    return pllirq_pkg::RESP_SLVERR;
  endfunction : rsp

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return m_ctrl | ((m_flag & m_auto) << 6);
      8'h04: return (m_auto << 7) | ((m_auto & m_lock) << 6);
      8'h08: return m_stat;
      8'h0C: return m_mask;
      default: return 0;
    endcase
  endfunction : exp_rd

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1 && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1 && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(rsp(a)));
    if (a == 8'h00 && !(m_brk && !m_bce)) m_flag = 0;
    if (a == 8'h00) m_ctrl = d[7:0] & 8'hB0;
    if (a == 8'h04) m_auto = d[7];
    if (a == 8'h04 && !d[7]) m_flag = 0;
    if (a == 8'h08) m_stat = m_stat & ~int'(d[1:0]);
    if (a == 8'h0C) m_mask = d[1:0];
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge clock);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'b1 && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata & m, exp_rd(a) & m);
    chk("rresp", 32'(s_axi_rresp), 32'(rsp(a)));
    if (a == 8'h00 && !(m_brk && !m_bce)) m_flag = 0;
  endtask : rd

  task automatic lk(input logic v);
    @(posedge clock);
    vco_locked <= v;
    repeat (8) @(posedge clock);
    m_lock = v;
    if (m_auto) m_flag = 1;
    if (m_auto) m_stat = m_stat | 1;
  endtask : lk

  // ----------------------------------------
  // clock, free-running levels, watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    if (rst_n !== 1'b1) begin
      rng       <= 32'h25;
      vco_level <= 1'b0;
      osc_level <= 1'b0;
    end else begin
      rng       <= xs(rng);
      vco_level <= rng[0];
      osc_level <= ~osc_level;
    end
  end

  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    {vco_locked, keep_osc_in_stop, stop_mode} = '0;
    {break_state, break_clear_enable, go_wait, rst_n} = '0;
    m_ctrl = pllirq_pkg::RST_LOOP_CTRL;
    {m_auto, m_flag, m_lock, m_stat, m_mask, errors, n_checks} = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h00);
    rd(8'h04);
    rd(8'h14);
    wr(8'h20, rng);
    wr(8'h00, 32'h30);
    rd(8'h00);
    wr(8'h00, 32'hA0);
    lk(1'b1);
    lk(1'b0);
    chk("cgirq_off", 32'(clockgen_irq), 0);
    rd(8'h00);
    wr(8'h04, 32'hC0);
    rd(8'h04);
    wr(8'h00, 32'h20);
    wr(8'h08, 32'h3);
    lk(1'b1);
    chk("cgirq_dis", 32'(clockgen_irq), 0);
    rd(8'h08, 32'h1);
    rd(8'h00);
    rd(8'h00);
    rd(8'h04);
    wr(8'h00, 32'hA0);
    wr(8'h0C, 32'h1);
    lk(1'b0);
    chk("cgirq_on", 32'(clockgen_irq), 1);
    chk("irq_out_on", 32'(irq_out), 1);
    wr(8'h0C, 32'h0);
    repeat (2) @(posedge clock);
    chk("irq_out_mask", 32'(irq_out), 0);
    repeat (20) @(posedge clock);
    chk("cgirq_hold", 32'(clockgen_irq), 1);
    stop_mode <= 1'b1;
    repeat (6) @(posedge clock);
    repeat (8) begin
      @(posedge clock);
      chk("xclk_stop", 32'(crystal_clock), 0);
      chk("bclk_stop", 32'(base_clock_out), 0);
      chk("cgirq_stop", 32'(clockgen_irq), 0);
    end
    chk("osc_en_stop", 32'(osc_enable), 0);
    chk("pll_en_stop", 32'(pll_enable), 0);
    stop_mode <= 1'b0;
    repeat (8) @(posedge clock);
    chk("cgirq_back", 32'(clockgen_irq), 1);
    keep_osc_in_stop <= 1'b1;
    stop_mode <= 1'b1;
    repeat (6) @(posedge clock);
    t = crystal_clock;
    tog = 0;
    repeat (8) begin
      @(posedge clock);
      if (crystal_clock !== t) tog++;
      t = crystal_clock;
    end
    chk("xclk_runs", 32'(tog > 0), 1);
    chk("osc_en_keep", 32'(osc_enable), 1);
    chk("pll_en_keep", 32'(pll_enable), 0);
    stop_mode <= 1'b0;
    keep_osc_in_stop <= 1'b0;
    break_state <= 1'b1;
    m_brk = 1;
    repeat (8) @(posedge clock);
    rd(8'h00);
    wr(8'h00, 32'hA0);
    rd(8'h00);
    break_clear_enable <= 1'b1;
    m_bce = 1;
    repeat (6) @(posedge clock);
    rd(8'h00);
    break_state <= 1'b0;
    break_clear_enable <= 1'b0;
    {m_brk, m_bce} = '0;
    repeat (6) @(posedge clock);
    rd(8'h00);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'hA0);
    go_wait <= 1'b1;
    @(posedge clock);
    go_wait <= 1'b0;
    repeat (6) @(posedge clock);
    chk("in_wait", 32'(wait_mode), 1);
    chk("pll_en_wait", 32'(pll_enable), 1);
    chk("osc_en_wait", 32'(osc_enable), 1);
    lk(1'b1);
    repeat (12) if (wait_mode !== 1'b0) @(posedge clock);
    chk("woken", 32'(wait_mode), 0);
    rd(8'h00);
    close_out();
  end
endmodule : test_pll_lock_interrupt_lowpower
